// ### src/pmc_pkg.sv
// pmc_pkg: register map, field layout, reset values, timing and types of the power mode block
// assumes: 250 MHz core clock; registers reached over axi4-lite, one word per register index
package pmc_pkg;

   localparam int CLK_MHZ = 250;

   // low-power entry/exit qualification times and nv programming time
   localparam int ENTER_US   = 100;
   localparam int EXIT_US    = 10;
   localparam int NV_PROG_MS = 24;

   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_SPEED  = 6'h00;
   localparam logic [5:0] IDX_CFG    = 6'h01;
   localparam logic [5:0] IDX_DECODE = 6'h02;
   localparam logic [5:0] IDX_DEVCTL = 6'h03;
   localparam logic [5:0] IDX_NVCTL  = 6'h04;
   localparam logic [5:0] IDX_STATUS = 6'h10;
   localparam logic [5:0] IDX_PARAM0 = 6'h20;
   localparam logic [5:0] IDX_PARAMN = 6'h2B;
   localparam int         NV_BYTES   = 12;

   // field positions
   localparam int NVCTL_TRIG_BIT = 0;
   localparam int NVCTL_SRC_BIT  = 1;
   localparam int STATUS_LP_BIT  = 6;
   localparam int DEC_BEMF_LSB   = 16;

   localparam logic [7:0]  UNLOCK_KEY = 8'hB6;
   localparam logic [8:0]  PWM_TOP    = 9'h1FD;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   // reset values
   localparam logic [8:0]  SPEED_RST = 9'h000;
   localparam logic [4:0]  CFG_RST   = 5'h00;
   localparam logic [95:0] NV_RST    = 96'h0;

   typedef enum logic [1:0] {
      PMC_MODE_ANALOG = 2'h0,
      PMC_MODE_PWM    = 2'h1,
      PMC_MODE_SERIAL = 2'h2
   } pmc_mode_e;

   typedef enum logic [1:0] {
      PMC_ST_RUN  = 2'b01,
      PMC_ST_LOWP = 2'b10
   } pmc_lp_state_e;

   // configuration word: bit0 inhibit, [2:1] mode, bit3 sleep variant, bit4 analog wake pin
   typedef struct packed {
      logic      wake_ana;
      logic      sleep_var;
      pmc_mode_e mode;
      logic      low_power_inhibit;
   } pmc_cfg_s;

   // normalised three-phase waveform from the commutation core
   typedef struct packed {
      logic [2:0][8:0] level;
   } pmc_wave_s;

endpackage : pmc_pkg

// ### src/pmc_param_decode.sv
// pmc_param_decode: mantissa/exponent decode of a 7-bit motor parameter code
// assumes: code is stable from a register; result is combinational
`timescale 1ns/100ps
module pmc_param_decode (
   // code in
   input  wire logic [6:0]  code,
   // scaled value out
   output logic      [10:0] scaled
);
   // mantissa [3:0] shifted left by exponent [6:4]; all ones gives 15 << 7
   assign scaled = {7'h00, code[3:0]} << code[6:4];
endmodule : pmc_param_decode

// ### src/pmc_top.sv
// pmc_top: low-power mode control, peak duty pwm and non-volatile parameter store
// assumes: an axi4-lite master on core_clk; speed pin and comparators are asynchronous
// What this block does
// - peak output amplitude scales linearly with peak duty; full command drives full supply
// - third-harmonic coding: one phase held at ground, other two pulse modulated
// - entering sleep or standby stops driving the motor
// - sleep turns off regulator and serial port, resets volatile registers
// - standby keeps regulator, register contents and serial port alive
// - inhibit bit blocks entry to low power but never wakes the device
// - status bit 6 is set while in sleep or standby
// - analog mode: below entry level for entry time enters, above exit level exits
// - pwm mode: pin low for entry time enters, pin high for exit time exits
// - serial mode: zero speed command enters, non-zero command leaves standby
// - serial command cannot wake from sleep; only the speed pin, or the sleep exit comparator in analog mode or in serial mode with wake_ana set, can
// - motor parameters live in 96 bits of non-volatile storage
// - programming takes about 24 ms, then trigger clears itself
// - resistance code in first parameter register, back-emf code in second
// - resistance code is 4-bit mantissa shifted by 3-bit exponent
// - all-ones resistance code decodes to 1920; smallest supported value is 3
// - non-volatile contents copied to working registers at power-on and sleep exit
// - host register writes override non-volatile settings in operation
// - back-emf code uses the same decode; all ones is the maximum
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module pmc_top #(
   parameter int ENTER_CYC   = pmc_pkg::ENTER_US * pmc_pkg::CLK_MHZ,
   parameter int EXIT_CYC    = pmc_pkg::EXIT_US * pmc_pkg::CLK_MHZ,
   parameter int NV_PROG_CYC = pmc_pkg::NV_PROG_MS * 1000 * pmc_pkg::CLK_MHZ
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // axi4-lite slave
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // speed pin and analog comparators, asynchronous
   input  wire logic              speed_pin,
   input  wire logic              ana_below_entry,
   input  wire logic              ana_above_exit_sb,
   input  wire logic              ana_above_exit_sl,
   // core inputs, same clock
   input  wire logic [8:0]        duty_meas,
   input  wire pmc_pkg::pmc_wave_s wave,
   // power and drive outputs
   output logic [2:0]             phase_pwm,
   output logic                   phase_drive_en,
   output logic                   buck_en,
   output logic                   serial_en,
   output logic                   low_power,
   output logic [8:0]             peak_duty_output
);
   import pmc_pkg::*;

   logic [3:0]          pin_s1_ff, pin_s2_ff;
   pmc_cfg_s            cfg_ff;
   logic [8:0]          speed_cmd_ff;
   logic [7:0]          unlock_key_ff;
   logic                src_sel_ff, nv_busy_ff, load_pend_ff;
   logic [31:0]         nv_cnt_ff, lp_cnt_ff, nxt_lp_cnt;
   logic [7:0]          nv_store_ff [NV_BYTES];
   logic [7:0]          param_ff [NV_BYTES];
   pmc_lp_state_e       state_ff, nxt_state;
   logic                awready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]          bresp_ff, rresp_ff;
   logic [31:0]         rdata_ff, rd_word;
   logic                rd_ok;
   logic [8:0]          pwm_cnt_ff, peak_ff, lvl_min;
   logic [8:0]          duty_ff [3];
   logic [2:0]          phase_pwm_ff;
   logic                drive_en_ff, buck_en_ff, serial_en_ff, low_power_ff;
   logic                enter_cond, exit_cond;
   logic [10:0]         res_scaled, bemf_scaled;

   logic pin_hi, ana_low, ana_sb, ana_sl;
   assign pin_hi  = pin_s2_ff[0];
   assign ana_low = pin_s2_ff[1];
   assign ana_sb  = pin_s2_ff[2];
   assign ana_sl  = pin_s2_ff[3];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
      end else begin
         pin_s1_ff <= {ana_above_exit_sl, ana_above_exit_sb, ana_below_entry, speed_pin};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // ---------------- bus slave ----------------
   logic       wr_fire, rd_fire, bus_on, wr_ok, sleep_now;
   logic [5:0] wr_idx, rd_idx;
   assign wr_fire   = awready_ff && s_axi_awvalid && s_axi_wvalid;
   assign rd_fire   = arready_ff && s_axi_arvalid;
   assign wr_idx    = s_axi_awaddr[7:2];
   assign rd_idx    = s_axi_araddr[7:2];
   assign bus_on    = serial_en_ff && !load_pend_ff;
   assign sleep_now = (state_ff == PMC_ST_LOWP) && cfg_ff.sleep_var;

   function automatic logic pmc_mapped(input logic [5:0] idx);
      return (idx <= IDX_NVCTL) || (idx == IDX_STATUS) ||
             (idx >= IDX_PARAM0 && idx <= IDX_PARAMN);
   endfunction : pmc_mapped

   assign wr_ok = wr_fire && bus_on && pmc_mapped(wr_idx);

   // address and data are taken together once both are offered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_ff <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end else begin
         awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLV;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_word = 32'h0;
      rd_ok   = bus_on;
      case (rd_idx)
         IDX_SPEED:  rd_word = {23'h0, speed_cmd_ff};
         IDX_CFG:    rd_word = {27'h0, cfg_ff};
         IDX_DECODE: rd_word = {5'h0, bemf_scaled, 5'h0, res_scaled};
         IDX_DEVCTL: rd_word = {24'h0, unlock_key_ff};
         IDX_NVCTL:  rd_word = {30'h0, src_sel_ff, nv_busy_ff};
         IDX_STATUS: rd_word = {25'h0, low_power_ff, 6'h00};
         default: begin
            if (rd_idx >= IDX_PARAM0 && rd_idx <= IDX_PARAMN) begin
               rd_word = {24'h0, param_ff[4'(rd_idx - IDX_PARAM0)]};
            end else begin
               rd_ok = 1'b0;
            end
         end
      endcase
      if (!rd_ok) rd_word = 32'h0;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
         if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLV;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ---------------- control registers ----------------
   logic trig_req, trig_ok, nv_done;
   assign trig_req = wr_ok && (wr_idx == IDX_NVCTL) && s_axi_wstrb[0] &&
                     s_axi_wdata[NVCTL_TRIG_BIT];
   assign trig_ok  = trig_req && !nv_busy_ff && (unlock_key_ff == UNLOCK_KEY) &&
                     s_axi_wdata[NVCTL_SRC_BIT];
   assign nv_done  = nv_busy_ff && (nv_cnt_ff == 32'(NV_PROG_CYC - 1));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff        <= CFG_RST;
         speed_cmd_ff  <= SPEED_RST;
         unlock_key_ff <= 8'h00;
         src_sel_ff    <= 1'b0;
      end else if (sleep_now) begin
         speed_cmd_ff  <= SPEED_RST;
         unlock_key_ff <= 8'h00;
         src_sel_ff    <= 1'b0;
      end else begin
         if (wr_ok && s_axi_wstrb[0]) begin
            if (wr_idx == IDX_CFG) cfg_ff <= s_axi_wdata[4:0];
            if (wr_idx == IDX_SPEED) speed_cmd_ff[7:0] <= s_axi_wdata[7:0];
            if (wr_idx == IDX_DEVCTL) unlock_key_ff <= s_axi_wdata[7:0];
            if (wr_idx == IDX_NVCTL) src_sel_ff <= s_axi_wdata[NVCTL_SRC_BIT];
         end
         if (wr_ok && s_axi_wstrb[1] && wr_idx == IDX_SPEED) begin
            speed_cmd_ff[8] <= s_axi_wdata[8];
         end
         if (nv_done) unlock_key_ff <= 8'h00;
      end
   end

   // programming timer; trigger reads back as busy and clears itself when done
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_busy_ff <= 1'b0;
         nv_cnt_ff  <= 32'h0;
      end else if (nv_done) begin
         nv_busy_ff <= 1'b0;
         nv_cnt_ff  <= 32'h0;
      end else if (nv_busy_ff) begin
         nv_cnt_ff  <= nv_cnt_ff + 32'h1;
      end else if (trig_ok) begin
         nv_busy_ff <= 1'b1;
      end
   end

   // reload working registers from the store after reset and after sleep exit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_pend_ff <= 1'b1;
      end else begin
         load_pend_ff <= (state_ff == PMC_ST_LOWP) && (nxt_state == PMC_ST_RUN) &&
                         cfg_ff.sleep_var;
      end
   end

   for (genvar i = 0; i < NV_BYTES; i++) begin : g_nv
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            nv_store_ff[i] <= NV_RST[i*8 +: 8];
         end else if (nv_done) begin
            nv_store_ff[i] <= param_ff[i];
         end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            param_ff[i] <= NV_RST[i*8 +: 8];
         end else if (load_pend_ff) begin
            param_ff[i] <= nv_store_ff[i];
         end else if (wr_ok && s_axi_wstrb[0] && wr_idx == IDX_PARAM0 + 6'(i)) begin
            param_ff[i] <= s_axi_wdata[7:0];
         end
      end
   end

   pmc_param_decode u_res_dec (
      .code   (param_ff[0][6:0]),
      .scaled (res_scaled)
   );
   pmc_param_decode u_bemf_dec (
      .code   (param_ff[1][6:0]),
      .scaled (bemf_scaled)
   );

   // ---------------- low-power state ----------------
   always_comb begin
      case (cfg_ff.mode)
         PMC_MODE_ANALOG: enter_cond = ana_low;
         PMC_MODE_PWM:    enter_cond = !pin_hi;
         default:         enter_cond = (speed_cmd_ff == 9'h000);
      endcase
      if (cfg_ff.sleep_var) begin
         // serial port is off in sleep, so only the pin or the sleep exit comparator can wake
         if (cfg_ff.mode == PMC_MODE_ANALOG ||
             (cfg_ff.mode == PMC_MODE_SERIAL && cfg_ff.wake_ana)) begin
            exit_cond = ana_sl;
         end else begin
            exit_cond = pin_hi;
         end
      end else begin
         case (cfg_ff.mode)
            PMC_MODE_ANALOG: exit_cond = ana_sb;
            PMC_MODE_PWM:    exit_cond = pin_hi;
            default:         exit_cond = (speed_cmd_ff != 9'h000);
         endcase
      end
   end

   always_comb begin
      nxt_state  = state_ff;
      nxt_lp_cnt = 32'h0;
      case (state_ff)
         PMC_ST_RUN: begin
            if (enter_cond && !cfg_ff.low_power_inhibit) begin
               if (lp_cnt_ff == 32'(ENTER_CYC - 1)) nxt_state = PMC_ST_LOWP;
               else nxt_lp_cnt = lp_cnt_ff + 32'h1;
            end
         end
         PMC_ST_LOWP: begin
            if (exit_cond) begin
               if (lp_cnt_ff == 32'(EXIT_CYC - 1)) nxt_state = PMC_ST_RUN;
               else nxt_lp_cnt = lp_cnt_ff + 32'h1;
            end
         end
         default: nxt_state = PMC_ST_RUN;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff     <= PMC_ST_RUN;
         lp_cnt_ff    <= 32'h0;
         low_power_ff <= 1'b0;
         drive_en_ff  <= 1'b1;
         buck_en_ff   <= 1'b1;
         serial_en_ff <= 1'b1;
      end else begin
         state_ff     <= nxt_state;
         lp_cnt_ff    <= nxt_lp_cnt;
         low_power_ff <= (nxt_state == PMC_ST_LOWP);
         drive_en_ff  <= (nxt_state == PMC_ST_RUN);
         buck_en_ff   <= !((nxt_state == PMC_ST_LOWP) && cfg_ff.sleep_var);
         serial_en_ff <= !((nxt_state == PMC_ST_LOWP) && cfg_ff.sleep_var);
      end
   end

   // ---------------- amplitude and phase pwm ----------------
   always_comb begin
      lvl_min = wave.level[0];
      if (wave.level[1] < lvl_min) lvl_min = wave.level[1];
      if (wave.level[2] < lvl_min) lvl_min = wave.level[2];
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_cnt_ff <= 9'h000;
         peak_ff    <= 9'h000;
      end else begin
         pwm_cnt_ff <= (pwm_cnt_ff == PWM_TOP) ? 9'h000 : pwm_cnt_ff + 9'h001;
         peak_ff    <= (cfg_ff.mode == PMC_MODE_SERIAL) ? speed_cmd_ff : duty_meas;
      end
   end

   for (genvar p = 0; p < 3; p++) begin : g_phase
      logic [17:0] prod;
      // lowest phase sits at zero, amplitude scales with peak duty
      assign prod = 18'(wave.level[p] - lvl_min) * 18'(peak_ff);
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            duty_ff[p]      <= 9'h000;
            phase_pwm_ff[p] <= 1'b0;
         end else begin
            duty_ff[p]      <= prod[17:9];
            phase_pwm_ff[p] <= (nxt_state == PMC_ST_RUN) && (pwm_cnt_ff < duty_ff[p]);
         end
      end
   end

   assign s_axi_awready    = awready_ff;
   assign s_axi_wready     = awready_ff;
   assign s_axi_bresp      = bresp_ff;
   assign s_axi_bvalid     = bvalid_ff;
   assign s_axi_arready    = arready_ff;
   assign s_axi_rdata      = rdata_ff;
   assign s_axi_rresp      = rresp_ff;
   assign s_axi_rvalid     = rvalid_ff;
   assign phase_pwm        = phase_pwm_ff;
   assign phase_drive_en   = drive_en_ff;
   assign buck_en          = buck_en_ff;
   assign serial_en        = serial_en_ff;
   assign low_power        = low_power_ff;
   assign peak_duty_output = peak_ff;

   // ---------------- assertions ----------------
   AST_LP_STOPS_DRIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(low_power_ff) |-> !drive_en_ff && phase_pwm_ff == 3'b000)
      else $error("drive still active in low power");
   AST_SLEEP_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      low_power_ff && cfg_ff.sleep_var && $stable(cfg_ff) |-> !buck_en_ff && !serial_en_ff)
      else $error("regulator or serial alive in sleep");
   AST_STANDBY_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
      low_power_ff && !$past(cfg_ff.sleep_var) |-> buck_en_ff && serial_en_ff)
      else $error("standby dropped regulator or serial port");
   AST_INHIBIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_ff == PMC_ST_RUN && cfg_ff.low_power_inhibit |=> !low_power_ff)
      else $error("entered low power while inhibited");
   AST_LP_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_fire && rd_idx == IDX_STATUS && bus_on |=> rdata_ff[STATUS_LP_BIT] == $past(low_power_ff))
      else $error("status flag does not track low power");
   AST_ENTRY_TIME: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_ff == PMC_ST_RUN && lp_cnt_ff != 32'(ENTER_CYC - 1) |=> state_ff == PMC_ST_RUN)
      else $error("low power entered before entry time");
   AST_SERIAL_NO_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_ff == PMC_ST_LOWP && cfg_ff.sleep_var && !pin_hi && !ana_sl |=> state_ff == PMC_ST_LOWP)
      else $error("woke from sleep without pin");
   AST_NV_DONE: assert property (@(posedge core_clk) disable iff (!rst_n)
      nv_done |=> !nv_busy_ff && nv_store_ff[0] == $past(param_ff[0]))
      else $error("programming did not complete");
   AST_NV_KEY: assert property (@(posedge core_clk) disable iff (!rst_n)
      trig_req && !nv_busy_ff && unlock_key_ff != UNLOCK_KEY |=> !nv_busy_ff)
      else $error("trigger accepted without key");
   AST_NV_BUSY: assert property (@(posedge core_clk) disable iff (!rst_n)
      nv_busy_ff && !nv_done |=> nv_busy_ff && nv_cnt_ff == $past(nv_cnt_ff) + 32'h1)
      else $error("programming cycle disturbed");
   AST_ZERO_PHASE: assert property (@(posedge core_clk) disable iff (!rst_n)
      duty_ff[0] == 9'h000 || duty_ff[1] == 9'h000 || duty_ff[2] == 9'h000)
      else $error("no phase held at ground");
   AST_RELOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      load_pend_ff |=> param_ff[1] == $past(nv_store_ff[1]))
      else $error("working registers not reloaded");

endmodule : pmc_top

// ### bench/pmc_host_model.sv
// pmc_host_model: axi4-lite host that reads and writes the power mode registers
// assumes: one access at a time; signals change by nba just after a rising edge
`timescale 1ns/100ps
module pmc_host_model (
   // clock
   input  wire logic        core_clk,
   // write side
   output logic [7:0]       awaddr,
   output logic [31:0]      wdata,
   output logic             awvalid, wvalid, bready,
   input  wire logic        awready, wready, bvalid,
   input  wire logic [1:0]  bresp,
   // read side
   output logic [7:0]       araddr,
   output logic             arvalid, rready,
   input  wire logic        arready, rvalid,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp
);
   initial {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
   // released address and data lines show the inverse of their last value
   task automatic xfer(input logic we, input logic [5:0] i, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
      logic aw_p, w_p;
      @(posedge core_clk);
      q = d;
      if (we) begin
         awaddr <= {i, 2'h0};
         wdata <= d;
         {awvalid, wvalid, bready} <= 3'b111;
         {aw_p, w_p} = 2'b11;
         // each channel is released at the edge that takes it
         while (aw_p || w_p) begin
            @(posedge core_clk);
            if (aw_p && awready === 1'b1) begin
               aw_p = 1'b0;
               awvalid <= 1'b0;
               awaddr <= ~awaddr;
            end
            if (w_p && wready === 1'b1) begin
               w_p = 1'b0;
               wvalid <= 1'b0;
               wdata <= ~d;
            end
         end
         while (bvalid !== 1'b1) @(posedge core_clk);
         r = bresp;
         bready <= 1'b0;
      end else begin
         araddr <= {i, 2'h0};
         {arvalid, rready} <= 2'b11;
         do @(posedge core_clk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         araddr <= ~araddr;
         while (rvalid !== 1'b1) @(posedge core_clk);
         {q, r} = {rdata, rresp};
         rready <= 1'b0;
      end
   endtask : xfer
endmodule : pmc_host_model

// ### bench/pmc_top_tb.sv
// pmc_top_tb: self-checking bench for pmc_top with a host model on the register bus
// assumes: counts shortened to 20, 10 and 50 cycles; analog comparators driven as levels
`timescale 1ns/100ps
module pmc_top_tb;
   import pmc_pkg::*;
   localparam int EN = 20;
   localparam int EX = 10;
   localparam int NVC = 50;
   logic core_clk, rst_n, speed_pin, awvalid, awready, wvalid, bvalid, bready;
   logic arvalid, arready, rvalid, rready, buck_en, serial_en, low_power, drive_en, wready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, r;
   logic [2:0] pwm, ana;
   logic [8:0] duty, peak;
   pmc_wave_s wave;
   int errors, checked, n, a, s, p;
   int unsigned seed = 19;
   pmc_top #(.ENTER_CYC(EN), .EXIT_CYC(EX), .NV_PROG_CYC(NVC)) pmc_top_i (
      .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .speed_pin(speed_pin), .ana_below_entry(ana[0]), .ana_above_exit_sb(ana[1]),
      .ana_above_exit_sl(ana[2]), .duty_meas(duty), .wave(wave), .phase_pwm(pwm),
      .phase_drive_en(drive_en), .buck_en(buck_en), .serial_en(serial_en),
      .low_power(low_power), .peak_duty_output(peak));
   pmc_host_model pmc_host_model_i (.core_clk(core_clk), .awaddr(awaddr), .wdata(wdata),
      .awvalid(awvalid), .wvalid(wvalid), .bready(bready), .awready(awready), .bvalid(bvalid),
      .bresp(bresp), .araddr(araddr), .arvalid(arvalid), .rready(rready), .arready(arready),
      .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .wready(wready));
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic int dec(input int c);
      return (c & 15) << (c >> 4 & 7);
   endfunction : dec
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic we, input logic [5:0] i, input logic [31:0] d,
                      input logic [1:0] e);
      pmc_host_model_i.xfer(we, i, d, v, r);
      check({30'h0, r}, {30'h0, e});
   endtask : acc
   // edges until low_power reaches lv, allowing sync and state latency
   task automatic wait_lp(input logic lv, input int lo);
      for (n = 0; n < lo + 40 && low_power !== lv; n++) @(posedge core_clk);
      check(n >= lo - 2 && n <= lo + 6, 1);
   endtask : wait_lp
   task automatic complete_run();
      $display("checked %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      #(20000 * 4);
      errors++;
      complete_run();
   end
   initial begin
      {rst_n, speed_pin, ana, duty, wave} = {2'b01, 39'h0};
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      for (int k = 0; k < 9; k++) begin
         p = (k == 0) ? 127 : rnd() & 127;
         s = (k == 0) ? 127 : rnd() & 127;
         acc(1, IDX_PARAM0, p, RESP_OKAY);
         acc(1, IDX_PARAM0 + 6'h01, s, RESP_OKAY);
         acc(0, IDX_DECODE, 0, RESP_OKAY);
         check(v, dec(s) << 16 | dec(p));
      end
      acc(0, 6'h3F, 0, RESP_SLV);
      check(v, 0);
      $display("decode test done");
      acc(1, IDX_NVCTL, 32'h2, RESP_OKAY);
      acc(1, IDX_NVCTL, 32'h3, RESP_OKAY);
      acc(0, IDX_NVCTL, 0, RESP_OKAY);
      check(v[0], 0);
      acc(1, IDX_DEVCTL, UNLOCK_KEY, RESP_OKAY);
      acc(1, IDX_NVCTL, 32'h3, RESP_OKAY);
      a = $time;
      acc(0, IDX_NVCTL, 0, RESP_OKAY);
      check(v[0], 1);
      repeat (25) @(posedge core_clk);
      acc(1, IDX_DEVCTL, UNLOCK_KEY, RESP_OKAY);
      acc(1, IDX_NVCTL, 32'h3, RESP_OKAY);
      for (n = 0; n < 40 && v[0] !== 1'b0; n++) acc(0, IDX_NVCTL, 0, RESP_OKAY);
      s = ($time - a) / 4;
      check(s >= NVC - 4 && s <= NVC + 8, 1);
      acc(0, IDX_DEVCTL, 0, RESP_OKAY);
      check(v, 0);
      acc(1, IDX_PARAM0, p ^ 32'h55, RESP_OKAY);
      $display("nv program test done");
      s = rnd() & 511;
      duty <= 9'(rnd());
      wave <= {9'h1FF, 9'(s), 9'h000};
      acc(1, IDX_CFG, 32'h2, RESP_OKAY);
      repeat (4) @(posedge core_clk);
      check(peak, duty);
      {a, n} = '0;
      repeat (510) begin
         @(posedge core_clk);
         a += pwm[1];
         n += pwm[0];
      end
      check(a, (s * duty) >> 9);
      check(n, 0);
      speed_pin <= 1'b0;
      wait_lp(1'b1, EN);
      check({drive_en, buck_en, serial_en}, 3'b011);
      acc(0, IDX_STATUS, 0, RESP_OKAY);
      check(v[STATUS_LP_BIT], 1);
      acc(1, IDX_CFG, 32'h3, RESP_OKAY);
      acc(0, IDX_PARAM0, 0, RESP_OKAY);
      check(v, p ^ 32'h55);
      check(low_power, 1);
      speed_pin <= 1'b1;
      wait_lp(1'b0, EX);
      speed_pin <= 1'b0;
      repeat (3 * EN) @(posedge core_clk);
      check(low_power, 0);
      acc(1, IDX_CFG, 32'h0, RESP_OKAY);
      ana <= 3'b001;
      wait_lp(1'b1, EN);
      ana <= 3'b010;
      wait_lp(1'b0, EX);
      $display("standby test done");
      acc(1, IDX_SPEED, 32'h100, RESP_OKAY);
      acc(1, IDX_CFG, 32'hC, RESP_OKAY);
      acc(1, IDX_SPEED, 32'h0, RESP_OKAY);
      wait_lp(1'b1, EN);
      check({drive_en, buck_en, serial_en}, 3'b000);
      acc(1, IDX_SPEED, 32'h9, RESP_SLV);
      repeat (3 * EX) @(posedge core_clk);
      check(low_power, 1);
      speed_pin <= 1'b1;
      wait_lp(1'b0, EX);
      acc(0, IDX_PARAM0, 0, RESP_OKAY);
      check(v, p);
      acc(0, IDX_SPEED, 0, RESP_OKAY);
      check(v, 0);
      $display("sleep test done");
      complete_run();
   end
endmodule : pmc_top_tb
